// *** common/swst_regs.vh ***
// Register offsets, field positions, reset values and timing counts of the slow timers.
// Assumes a 32-bit APB slave decoding full byte addresses.
`ifndef SWST_REGS_VH
`define SWST_REGS_VH
`define SWST_CLKEN_ADDR     32'h4000_0008
`define SWST_WDCFG_ADDR     32'h4000_6000
`define SWST_WDUNL_ADDR     32'h4000_6004
`define SWST_WDRST_ADDR     32'h4000_6008
`define SWST_STCFG_ADDR     32'h4000_600c
`define SWST_CNTH_ADDR      32'h4000_6010
`define SWST_CNTL_ADDR      32'h4000_6014
`define SWST_CMPAH_ADDR     32'h4000_6018
`define SWST_CMPAL_ADDR     32'h4000_601c
`define SWST_CMPBH_ADDR     32'h4000_6020
`define SWST_CMPBL_ADDR     32'h4000_6024
`define SWST_FLAG_ADDR      32'h4000_a014
`define SWST_MASK_ADDR      32'h4000_a054
`define SWST_CLKEN_RST      32'h0000_0002
`define SWST_WDCFG_RST      32'h0000_0002
`define SWST_STCFG_RST      32'h0000_0400
`define SWST_CMP_RST        16'hffff
`define SWST_CODE_OFF       16'hdead
`define SWST_CODE_ON        16'heabe
`define SWST_WD_ON_BIT      0
`define SWST_WD_OFF_BIT     1
`define SWST_RCKEEP_BIT     1
`define SWST_DIR_BIT        12
`define SWST_RUN_BIT        11
`define SWST_FRZ_BIT        10
`define SWST_PRE_HI         7
`define SWST_PRE_LO         4
`define SWST_SEL_BIT        0
`define SWST_WRAP_BIT       0
`define SWST_CMPA_BIT       1
`define SWST_CMPB_BIT       2
`define SWST_WD_TIMEOUT_MS  2048
`define SWST_WD_WARN_MS     1792
`define SWST_RUN_SYNC_TICKS 2
`endif

// *** core/swst_tick_sync.v ***
// Edge detector turning a slow reference level into one-cycle tick pulses.
// Assumes the reference is synchronous to clk (slow relative to it).
`timescale 1ns/1ps
module swst_tick_sync
(
    input  wire clk,
    input  wire sys_rst,
    input  wire ref_level,
    output reg  tick
);
    reg prev;

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            // Track the level through reset so a high reference gives no false edge
            prev <= ref_level;
            tick <= 1'b0;
        end
        else
        begin
            prev <= ref_level;
            tick <= ref_level & ~prev;
        end
    end
endmodule

// *** core/swst_top.v ***
// Slow watchdog and sleep timer with its APB register file.
// Assumes slow reference clocks arrive as levels synchronous to clk, and that
// priv_system is high for bus accesses made from the processor's System mode.
`timescale 1ns/1ps
`include "swst_regs.vh"
module swst_top
#(
    parameter WD_TIMEOUT = `SWST_WD_TIMEOUT_MS,
    parameter WD_WARN    = `SWST_WD_WARN_MS
)
(
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        priv_system,
    input  wire        kilohertz_reference,
    input  wire        crystal_32k_clock,
    input  wire        cpu_halted,
    input  wire        cpu_clock_tick,
    input  wire        core_tick_src_sleep,
    input  wire        deep_sleep_request,
    output reg         core_tick_timer_tick,
    output reg         rc_off_sleep,
    output reg         rc_on_sleep,
    output reg         slow_timer_irq,
    output reg         wd_warning_nmi,
    output reg         wd_expired,
    output reg         wd_running
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [31:0] clk_src_en;
    reg        wd_on_request;
    reg        wd_off_request;
    reg        arm_on;
    reg        arm_off;
    reg [11:0] wd_count;
    reg        count_direction;
    reg        slow_timer_run;
    reg        halt_freeze;
    reg [3:0]  prescale_exponent;
    reg        slow_clock_choice;
    reg [31:0] count;
    reg [15:0] lower_snap;
    reg [31:0] cmp_a;
    reg [31:0] cmp_b;
    reg [15:0] hold_a;
    reg [15:0] hold_b;
    reg [2:0]  flags;
    reg [2:0]  mask;
    reg [14:0] pre_cnt;
    reg [1:0]  run_sync;
    reg        running;

    wire kilo_tick;
    wire xtal_tick;

    // ------------------------------------------------------------
    // Reference edge detection
    // ------------------------------------------------------------
    swst_tick_sync u_kilo
    (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .ref_level (kilohertz_reference),
        .tick      (kilo_tick)
    );

    swst_tick_sync u_xtal
    (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .ref_level (crystal_32k_clock),
        .tick      (xtal_tick)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    function [31:0] lo16;
        input [15:0] v;
        begin
            lo16 = {16'h0000, v};
        end
    endfunction

    function mapped;
        input [31:0] a;
        begin
            case (a)
                `SWST_CLKEN_ADDR, `SWST_WDCFG_ADDR, `SWST_WDUNL_ADDR,
                `SWST_WDRST_ADDR, `SWST_STCFG_ADDR, `SWST_CNTH_ADDR,
                `SWST_CNTL_ADDR, `SWST_CMPAH_ADDR, `SWST_CMPAL_ADDR,
                `SWST_CMPBH_ADDR, `SWST_CMPBL_ADDR, `SWST_FLAG_ADDR,
                `SWST_MASK_ADDR: mapped = 1'b1;
                default:         mapped = 1'b0;
            endcase
        end
    endfunction

    // Access completes in the second access cycle: pready pulses then
    wire acc  = psel & penable & ~pready;
    wire wr   = acc & pwrite & priv_system & mapped(paddr);
    wire rd   = acc & ~pwrite;
    wire stopped = ~slow_timer_run & ~running;

    // Slow clock selected for the sleep timer
    wire sel_tick = slow_clock_choice ? xtal_tick : kilo_tick;
    wire [14:0] pre_mask = (15'h0001 << prescale_exponent) - 15'h0001;
    wire pre_tick = sel_tick & ((pre_cnt & pre_mask) == pre_mask);
    wire step = pre_tick & running & ~(halt_freeze & cpu_halted);

    wire [31:0] next_count = count_direction ? count - 32'h0000_0001
                                             : count + 32'h0000_0001;
    wire        wrap_now = count_direction ? (count == 32'h0000_0000)
                                           : (count == 32'hffff_ffff);

    reg [31:0] next_rdata;
    always @*
    begin
        next_rdata = 32'h0000_0000;
        case (paddr)
            `SWST_CLKEN_ADDR: next_rdata = clk_src_en;
            `SWST_WDCFG_ADDR: next_rdata = {30'h0000_0000, wd_off_request, wd_on_request};
            `SWST_STCFG_ADDR: next_rdata = {19'h0_0000, count_direction, slow_timer_run,
                                            halt_freeze, 2'b00, prescale_exponent,
                                            3'b000, slow_clock_choice};
            `SWST_CNTH_ADDR:  next_rdata = lo16(count[31:16]);
            `SWST_CNTL_ADDR:  next_rdata = lo16(lower_snap);
            `SWST_CMPAH_ADDR: next_rdata = lo16(cmp_a[31:16]);
            `SWST_CMPAL_ADDR: next_rdata = lo16(cmp_a[15:0]);
            `SWST_CMPBH_ADDR: next_rdata = lo16(cmp_b[31:16]);
            `SWST_CMPBL_ADDR: next_rdata = lo16(cmp_b[15:0]);
            `SWST_FLAG_ADDR:  next_rdata = {29'h0000_0000, flags};
            `SWST_MASK_ADDR:  next_rdata = {29'h0000_0000, mask};
            default:          next_rdata = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= acc;
            pslverr <= acc & ~mapped(paddr);
            prdata  <= rd ? next_rdata : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            wd_on_request  <= 1'b0;
            wd_off_request <= 1'b1;
            arm_on         <= 1'b0;
            arm_off        <= 1'b0;
            wd_count       <= 12'h000;
            wd_running     <= 1'b0;
            wd_warning_nmi <= 1'b0;
            wd_expired     <= 1'b0;
        end
        else
        begin
            if (wr && paddr == `SWST_WDUNL_ADDR)
            begin
                arm_off <= (pwdata[15:0] == `SWST_CODE_OFF);
                arm_on  <= (pwdata[15:0] == `SWST_CODE_ON);
            end
            else if (wr && paddr == `SWST_WDCFG_ADDR)
            begin
                // Arming is consumed by the config write, so a stray second write fails
                // A granted request drops the opposite bit, else the disable bit set
                // at reset would block every later enable
                if (arm_on && pwdata[`SWST_WD_ON_BIT])
                begin
                    wd_on_request  <= 1'b1;
                    wd_off_request <= 1'b0;
                end
                if (arm_off && pwdata[`SWST_WD_OFF_BIT])
                begin
                    wd_off_request <= 1'b1;
                    wd_on_request  <= 1'b0;
                end
                arm_on  <= 1'b0;
                arm_off <= 1'b0;
            end
            // Disable dominates when both requests read set
            wd_running <= wd_on_request & ~wd_off_request;
            wd_warning_nmi <= 1'b0;
            wd_expired <= 1'b0;
            if (!wd_running || (wr && paddr == `SWST_WDRST_ADDR))
                wd_count <= 12'h000;
            else if (kilo_tick)
            begin
                // One count per millisecond of the kilohertz reference
                if (wd_count == WD_WARN[11:0] - 12'h001)
                    wd_warning_nmi <= 1'b1;
                if (wd_count == WD_TIMEOUT[11:0] - 12'h001)
                begin
                    wd_expired <= 1'b1;
                    wd_count   <= 12'h000;
                end
                else
                    wd_count <= wd_count + 12'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // Sleep timer
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            clk_src_en        <= `SWST_CLKEN_RST;
            count_direction   <= 1'b0;
            slow_timer_run    <= 1'b0;
            halt_freeze       <= 1'b1;
            prescale_exponent <= 4'h0;
            slow_clock_choice <= 1'b0;
            count      <= 32'h0000_0000;
            lower_snap <= 16'h0000;
            cmp_a      <= {`SWST_CMP_RST, `SWST_CMP_RST};
            cmp_b      <= {`SWST_CMP_RST, `SWST_CMP_RST};
            hold_a     <= `SWST_CMP_RST;
            hold_b     <= `SWST_CMP_RST;
            flags      <= 3'b000;
            mask       <= 3'b000;
            pre_cnt    <= 15'h0000;
            run_sync   <= 2'b00;
            running    <= 1'b0;
        end
        else
        begin
            if (wr && paddr == `SWST_CLKEN_ADDR)
                clk_src_en <= {30'h0000_0000, pwdata[1:0]};
            if (wr && paddr == `SWST_STCFG_ADDR)
            begin
                slow_timer_run <= pwdata[`SWST_RUN_BIT];
                halt_freeze    <= pwdata[`SWST_FRZ_BIT];
                if (stopped)
                begin
                    count_direction   <= pwdata[`SWST_DIR_BIT];
                    prescale_exponent <= pwdata[`SWST_PRE_HI:`SWST_PRE_LO];
                    slow_clock_choice <= pwdata[`SWST_SEL_BIT];
                end
            end
            // Enable passes through three selected-clock stages before acting
            if (sel_tick)
            begin
                run_sync <= {run_sync[0], slow_timer_run};
                running  <= run_sync[1];
            end
            if (!running)
                pre_cnt <= 15'h0000;
            else if (sel_tick)
                pre_cnt <= pre_cnt + 15'h0001;
            if (step)
                count <= next_count;
            if (rd && paddr == `SWST_CNTH_ADDR)
                lower_snap <= count[15:0];
            if (wr && paddr == `SWST_CMPAL_ADDR)
                hold_a <= pwdata[15:0];
            if (wr && paddr == `SWST_CMPAH_ADDR)
                cmp_a <= {pwdata[15:0], hold_a};
            if (wr && paddr == `SWST_CMPBL_ADDR)
                hold_b <= pwdata[15:0];
            if (wr && paddr == `SWST_CMPBH_ADDR)
                cmp_b <= {pwdata[15:0], hold_b};
            if (wr && paddr == `SWST_MASK_ADDR)
                mask <= pwdata[2:0];
            // Set wins over a same-cycle write-one clear
            flags[`SWST_WRAP_BIT] <= (step & wrap_now) |
                (flags[`SWST_WRAP_BIT] & ~(wr && paddr == `SWST_FLAG_ADDR
                                           && pwdata[`SWST_WRAP_BIT]));
            flags[`SWST_CMPA_BIT] <= (step & (next_count == cmp_a)) |
                (flags[`SWST_CMPA_BIT] & ~(wr && paddr == `SWST_FLAG_ADDR
                                           && pwdata[`SWST_CMPA_BIT]));
            flags[`SWST_CMPB_BIT] <= (step & (next_count == cmp_b)) |
                (flags[`SWST_CMPB_BIT] & ~(wr && paddr == `SWST_FLAG_ADDR
                                           && pwdata[`SWST_CMPB_BIT]));
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            slow_timer_irq       <= 1'b0;
            core_tick_timer_tick <= 1'b0;
            rc_off_sleep         <= 1'b0;
            rc_on_sleep          <= 1'b0;
        end
        else
        begin
            slow_timer_irq <= |(flags & mask);
            core_tick_timer_tick <= core_tick_src_sleep ? pre_tick : cpu_clock_tick;
            rc_off_sleep <= deep_sleep_request & ~clk_src_en[`SWST_RCKEEP_BIT];
            rc_on_sleep  <= deep_sleep_request & clk_src_en[`SWST_RCKEEP_BIT];
        end
    end
endmodule

// *** verification/swst_checker.sv ***
// Port-level checks of the slow watchdog and sleep timer block.
// Assumes it is bound onto swst_top and sees only that module's ports.
`timescale 1ns/1ps
`include "swst_regs.vh"
module swst_checker
(
    input wire        clk,
    input wire        sys_rst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] paddr,
    input wire        pready,
    input wire        pslverr,
    input wire        cpu_clock_tick,
    input wire        core_tick_src_sleep,
    input wire        deep_sleep_request,
    input wire        core_tick_timer_tick,
    input wire        rc_off_sleep,
    input wire        rc_on_sleep,
    input wire        slow_timer_irq,
    input wire        wd_warning_nmi,
    input wire        wd_expired,
    input wire        wd_running
);
    // Only a watchdog config write may move the running state
    wire wd_cfg_wr = psel & pwrite & (paddr == `SWST_WDCFG_ADDR);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_sleep_exclusive: assert property (!(rc_off_sleep && rc_on_sleep))
        else $error("both deep sleep kinds selected");
    a_sleep_follows: assert property (!$past(sys_rst) |->
        (rc_off_sleep || rc_on_sleep) == $past(deep_sleep_request))
        else $error("deep sleep kind does not follow request");
    a_tick_cpu_path: assert property (!$past(sys_rst) && !$past(core_tick_src_sleep)
        |-> core_tick_timer_tick == $past(cpu_clock_tick))
        else $error("core tick does not follow cpu clock tick");
    a_warn_pulse: assert property (wd_warning_nmi |=> !wd_warning_nmi)
        else $error("watchdog warning longer than one cycle");
    a_expire_running: assert property (wd_expired |-> $past(wd_running))
        else $error("watchdog expired while stopped");
    a_expire_gap: assert property (wd_expired |=> !wd_expired [*8])
        else $error("watchdog expired twice too close");
    a_run_by_write: assert property (!$past(sys_rst) && $changed(wd_running)
        |-> $past(wd_cfg_wr, 1) || $past(wd_cfg_wr, 2))
        else $error("watchdog state changed without config write");
    a_ready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("register access not answered next cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("slave error outside access end");
    a_clear_after_reset: assert property ($past(sys_rst) |-> !slow_timer_irq && !wd_running)
        else $error("interrupt or watchdog active after reset");
endmodule

bind swst_top swst_checker u_chk (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pready,
    .pslverr, .cpu_clock_tick, .core_tick_src_sleep, .deep_sleep_request, .core_tick_timer_tick,
    .rc_off_sleep, .rc_on_sleep, .slow_timer_irq, .wd_warning_nmi, .wd_expired, .wd_running);

// *** verification/swst_tb.sv ***
// Self-checking bench for the slow timer block, driven over APB.
// Assumes swst_top with shortened watchdog counts and fast slow references.
`timescale 1ns/1ps
`include "swst_regs.vh"
module testbench;
    logic        clk = 0;
    logic        sys_rst = 1;
    logic        psel = 0, penable = 0, pwrite = 0, rd_err;
    logic [31:0] paddr = 0, pwdata = 0, rd_data, snap, cnt0;
    logic        priv_system = 1, kilohertz_reference = 0, crystal_32k_clock = 0;
    logic        cpu_halted = 0, cpu_clock_tick = 0, core_tick_src_sleep = 0;
    logic        deep_sleep_request = 0;
    logic [2:0]  div = 0;
    wire  [31:0] prdata;
    wire         pready, pslverr, core_tick_timer_tick, rc_off_sleep, rc_on_sleep;
    wire         slow_timer_irq, wd_warning_nmi, wd_expired, wd_running;
    int          err_count = 0, checked = 0, n_warn = 0, n_exp = 0, i, k;

    swst_top #(.WD_TIMEOUT(16), .WD_WARN(12)) u_dut (.clk, .sys_rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .priv_system,
        .kilohertz_reference, .crystal_32k_clock, .cpu_halted, .cpu_clock_tick,
        .core_tick_src_sleep, .deep_sleep_request, .core_tick_timer_tick, .rc_off_sleep,
        .rc_on_sleep, .slow_timer_irq, .wd_warning_nmi, .wd_expired, .wd_running);

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------
    // Slow references and pulse counters
    // ----------------------------------------
    // References are far faster than real so the watchdog fits a short run
    always @(posedge clk)
    begin
        div <= div + 3'h1;
        crystal_32k_clock <= div[1];
        kilohertz_reference <= div[2];
        cpu_clock_tick <= ~cpu_clock_tick;
        if (wd_warning_nmi === 1'b1)
            n_warn <= n_warn + 1;
        if (wd_expired === 1'b1)
            n_exp <= n_exp + 1;
    end

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chkb(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask

    // Holds the request until pready is seen high at a rising edge
    // A missing answer is left to the bench timeout
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd_data);
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #(25 * 30000);
        err_count++;
        summarize();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`SWST_CLKEN_ADDR, 32'h0000_0002, "clken");
        rd(`SWST_WDCFG_ADDR, 32'h0000_0002, "wdcfg");
        rd(`SWST_STCFG_ADDR, 32'h0000_0400, "stcfg");
        rd(`SWST_CNTH_ADDR, 32'h0000_0000, "cnth");
        for (i = 0; i < 4; i++)
            rd(`SWST_CMPAH_ADDR + 32'(4 * i), 32'h0000_ffff, "cmp");
        rd(`SWST_FLAG_ADDR, 32'h0000_0000, "flags");
        rd(`SWST_MASK_ADDR, 32'h0000_0000, "mask");
        apb(1'b0, 32'h4000_6028, 32'h0000_0000);
        chkb("slverr", 1'b1, rd_err);
        priv_system <= 1'b0;
        apb(1'b1, `SWST_MASK_ADDR, 32'h0000_0007);
        priv_system <= 1'b1;
        rd(`SWST_MASK_ADDR, 32'h0000_0000, "mask_user");
        // Watchdog lock, restart and expiry
        apb(1'b1, `SWST_WDCFG_ADDR, 32'h0000_0001);
        rd(`SWST_WDCFG_ADDR, 32'h0000_0002, "wdcfg_locked");
        apb(1'b1, `SWST_WDUNL_ADDR, 32'h0000_eabe);
        apb(1'b1, `SWST_WDCFG_ADDR, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chkb("wd_on", 1'b1, wd_running);
        repeat (6)
        begin
            repeat (40) @(posedge clk);
            apb(1'b1, `SWST_WDRST_ADDR, 32'h0000_1234);
        end
        chk("expired_early", 0, n_exp);
        repeat (170) @(posedge clk);
        chk("warnings", 1, n_warn);
        chk("expiries", 1, n_exp);
        apb(1'b1, `SWST_WDUNL_ADDR, 32'h0000_1234);
        apb(1'b1, `SWST_WDCFG_ADDR, 32'h0000_0002);
        chkb("wd_disarmed", 1'b1, wd_running);
        apb(1'b1, `SWST_WDUNL_ADDR, 32'h0000_dead);
        apb(1'b1, `SWST_WDCFG_ADDR, 32'h0000_0002);
        repeat (2) @(posedge clk);
        chkb("wd_off", 1'b0, wd_running);
        // Compare double buffering, A at 3 and B at 4
        for (i = 0; i < 2; i++)
        begin
            apb(1'b1, `SWST_CMPAL_ADDR + 32'(8 * i), 32'h0000_0003 + 32'(i));
            rd(`SWST_CMPAL_ADDR + 32'(8 * i), 32'h0000_ffff, "cmp_lo_held");
            apb(1'b1, `SWST_CMPAH_ADDR + 32'(8 * i), 32'h0000_0000);
            rd(`SWST_CMPAH_ADDR + 32'(8 * i), 32'h0000_0000, "cmp_hi");
            rd(`SWST_CMPAL_ADDR + 32'(8 * i), 32'h0000_0003 + 32'(i), "cmp_lo");
        end
        // Count up on the crystal clock
        apb(1'b1, `SWST_MASK_ADDR, 32'h0000_0002);
        apb(1'b1, `SWST_STCFG_ADDR, 32'h0000_0801);
        k = 0;
        while (slow_timer_irq !== 1'b1 && k++ < 400) @(posedge clk);
        chkb("irq_a", 1'b1, slow_timer_irq);
        repeat (40) @(posedge clk);
        rd(`SWST_FLAG_ADDR, 32'h0000_0006, "flags_ab");
        apb(1'b1, `SWST_FLAG_ADDR, 32'h0000_0002);
        rd(`SWST_FLAG_ADDR, 32'h0000_0004, "flags_w1c");
        chkb("irq_masked", 1'b0, slow_timer_irq);
        rd(`SWST_CNTH_ADDR, 32'h0000_0000, "cnth_up");
        apb(1'b1, `SWST_STCFG_ADDR, 32'h0000_18f0);
        rd(`SWST_STCFG_ADDR, 32'h0000_0801, "stcfg_locked");
        // Stop, reverse, then count down through the wrap
        apb(1'b1, `SWST_STCFG_ADDR, 32'h0000_0001);
        repeat (40) @(posedge clk);
        apb(1'b1, `SWST_STCFG_ADDR, 32'h0000_1001);
        rd(`SWST_STCFG_ADDR, 32'h0000_1001, "stcfg_dir");
        apb(1'b1, `SWST_STCFG_ADDR, 32'h0000_1801);
        k = 0;
        do
            apb(1'b0, `SWST_FLAG_ADDR, 32'h0000_0000);
        while (rd_data[0] !== 1'b1 && ++k < 300);
        chkb("wrap_flag", 1'b1, rd_data[0]);
        rd(`SWST_CNTH_ADDR, 32'h0000_ffff, "cnth_down");
        apb(1'b1, `SWST_MASK_ADDR, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chkb("irq_wrap", 1'b1, slow_timer_irq);
        apb(1'b1, `SWST_FLAG_ADDR, 32'h0000_0007);
        repeat (2) @(posedge clk);
        chkb("irq_clear", 1'b0, slow_timer_irq);
        // Freeze while the debugger halts the cpu
        apb(1'b1, `SWST_STCFG_ADDR, 32'h0000_1c01);
        cpu_halted <= 1'b1;
        core_tick_src_sleep <= 1'b1;
        apb(1'b0, `SWST_CNTH_ADDR, 32'h0000_0000);
        apb(1'b0, `SWST_CNTL_ADDR, 32'h0000_0000);
        snap = rd_data;
        repeat (40) @(posedge clk);
        apb(1'b0, `SWST_CNTH_ADDR, 32'h0000_0000);
        rd(`SWST_CNTL_ADDR, snap, "cntl_frozen");
        cpu_halted <= 1'b0;
        // Deep sleep kind
        deep_sleep_request <= 1'b1;
        repeat (2) @(posedge clk);
        chkb("rc_on", 1'b1, rc_on_sleep);
        apb(1'b1, `SWST_CLKEN_ADDR, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chkb("rc_off", 1'b1, rc_off_sleep);
        // Kilohertz clock divided by four: exactly ten steps in 320 cycles
        apb(1'b1, `SWST_STCFG_ADDR, 32'h0000_0000);
        repeat (60) @(posedge clk);
        apb(1'b1, `SWST_STCFG_ADDR, 32'h0000_0820);
        repeat (100) @(posedge clk);
        apb(1'b0, `SWST_CNTH_ADDR, 32'h0000_0000);
        cnt0[31:16] = rd_data[15:0];
        apb(1'b0, `SWST_CNTL_ADDR, 32'h0000_0000);
        cnt0[15:0] = rd_data[15:0];
        repeat (312) @(posedge clk);
        apb(1'b0, `SWST_CNTH_ADDR, 32'h0000_0000);
        snap[31:16] = rd_data[15:0];
        apb(1'b0, `SWST_CNTL_ADDR, 32'h0000_0000);
        chk("prescaled_steps", 32'h0000_000a, {snap[31:16], rd_data[15:0]} - cnt0);
        summarize();
    end
endmodule
